// *** logic/spi_ctrl.sv ***
// SPI controller with transmit FIFO, master and slave shifting
`timescale 1ns/100ps
`include "spi_ctrl_defs.svh"

module spi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    wire              doWr = inValid && inReady;
    wire              doRd = outValid && outReady;

    assign inReady  = count_q != (AW+1)'(DEPTH);
    assign outValid = count_q != '0;
    assign outData  = mem_q[rdPtr_q];

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doWr) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doRd) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count_q <= count_q + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
        end
    end
endmodule

module spi_ctrl
    import spi_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           srst,
    // Control commands, one-cycle pulses
    input  wire logic                           enableCmd,
    input  wire logic                           disableCmd,
    input  wire logic                           softResetBit,
    // Mode configuration
    input  wire logic                           masterMode,
    input  wire logic                           modeFaultDetectDisable,
    input  wire logic [1:0]                     chipSelectIndex,
    input  wire spi_ctrl_pkg::cs_cfg_s          csConfig [`SPI_NUM_CS],
    // Transmit data register, DMA or software
    input  wire logic                           txWrite,
    input  wire logic [`SPI_WORD_BITS-1:0]      txData,
    output logic                                txReady,
    // Receive holding register read strobe
    input  wire logic                           rxRead,
    // Status
    output spi_ctrl_pkg::spi_status_s           status,
    output logic                                modeFault,
    // Serial pins
    output logic                                sckOut,
    output logic                                sckOe,
    input  wire logic                           sckIn,
    output logic                                mosiOut,
    output logic                                mosiOe,
    input  wire logic                           mosiIn,
    output logic                                misoOut,
    output logic                                misoOe,
    input  wire logic                           misoIn,
    output logic [`SPI_NUM_CS-1:0]              csOut_n,
    input  wire logic                           ssIn_n
);
    import spi_ctrl_pkg::*;

    logic                      enabled_q;
    logic                      txEmpty_q;
    logic                      receive_ready_flag_q;
    logic [`SPI_WORD_BITS-1:0] rxHold_q;
    logic [`SPI_WORD_BITS-1:0] shift_q;
    logic [2:0]                bitCnt_q;
    logic [`SPI_DIV_BITS-1:0]  divCnt_q;
    logic [`SPI_DIV_BITS-1:0]  prevDiv_q;
    logic                      extraPulse_q;
    logic                      sck_q;
    logic                      sckIn_q;
    logic                      ssIn_q;
    logic                      modeFault_q;
    logic                      csHeld_q;
    logic                      capBit_q;
    logic                      frameTail_q;
    xfer_state_e               state_q;
    logic                      fifoValid;
    logic [`SPI_WORD_BITS-1:0] fifoData;
    logic                      fifoInReady;

    cs_cfg_s cfg;
    assign cfg = csConfig[chipSelectIndex];

    // Soft reset stops the block; disable only acts in master mode
    wire doSoft   = softResetBit;
    wire doDis    = disableCmd && masterMode;
    // Disabled writes are filtered and lost, DMA or not
    wire acceptWr = txWrite && enabled_q;
    wire fifoPop;

    // Mode fault check stalls master start when select 0 is kept
    wire faultBlock = !modeFaultDetectDisable
                      && csConfig[0].keepSelectAfterTransfer;
    wire startMst = masterMode && enabled_q && fifoValid
                    && state_q == ST_IDLE && !faultBlock;
    wire divHit   = divCnt_q >= cfg.serialClockDivider - 1'b1
                    || cfg.serialClockDivider == '0;

    // Slave edges from the external clock
    wire slvSel   = !masterMode && enabled_q && !ssIn_q;
    wire sRise    = sckIn && !sckIn_q;
    wire sFall    = !sckIn && sckIn_q;
    wire sLead    = cfg.clockPolarity ? sFall : sRise;
    wire sTrail   = cfg.clockPolarity ? sRise : sFall;
    wire sampleOn = cfg.invertedClockPhase ? sLead : sTrail;
    wire mstSample;
    wire slvSample = slvSel && sampleOn;
    wire lastBit   = bitCnt_q == `SPI_BIT_LAST;
    wire serialIn  = masterMode ? misoIn : mosiIn;

    // Master: capture on one edge, change data on the other
    wire mstLead  = state_q == ST_LEAD && divHit && !extraPulse_q;
    wire mstTrail = state_q == ST_TRAIL && divHit;
    wire mstShift = cfg.invertedClockPhase ? mstTrail
                    : (mstLead && bitCnt_q != 3'h0);
    assign mstSample = cfg.invertedClockPhase ? mstLead : mstTrail;
    assign fifoPop   = startMst || (slvSel && fifoValid && bitCnt_q == 3'h0
                       && !csHeld_q);

    // Divider mismatch with polarity 1, phase 0 glitch
    wire mismatch = cfg.clockPolarity && !cfg.invertedClockPhase
                    && (prevDiv_q == `SPI_DIV_ONE)
                       != (cfg.serialClockDivider == `SPI_DIV_ONE);

    spi_fifo #(
        .WIDTH (`SPI_WORD_BITS),
        .DEPTH (`SPI_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .srst     (srst),
        .flush    (doSoft),
        .inValid  (acceptWr),
        .inReady  (fifoInReady),
        .inData   (txData),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    always_ff @(posedge clk) begin
        sckIn_q <= sckIn;
        ssIn_q  <= ssIn_n;
    end

    always_ff @(posedge clk) begin
        if (srst || doSoft) begin
            enabled_q <= 1'b0;
        end else if (enableCmd) begin
            enabled_q <= 1'b1;
        end else if (doDis) begin
            enabled_q <= 1'b0;
        end
    end

    // Empty flag follows accepted writes and FIFO drain, never disable
    always_ff @(posedge clk) begin
        if (srst || doSoft) begin
            txEmpty_q <= 1'b1;
        end else if (acceptWr) begin
            txEmpty_q <= 1'b0;
        end else if (!fifoValid) begin
            txEmpty_q <= 1'b1;
        end
    end

    // Receive flag: set wins over read; spurious set in slave at enable
    wire spurious = !masterMode && enableCmd && !sckIn;
    wire rxDone   = (mstSample || slvSample) && lastBit;
    always_ff @(posedge clk) begin
        if (srst || doSoft) begin
            receive_ready_flag_q <= 1'b0;
        end else if (rxDone || spurious) begin
            receive_ready_flag_q <= 1'b1;
        end else if (rxRead) begin
            receive_ready_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || doSoft) begin
            rxHold_q <= `SPI_DATA_RESET;
        end else if (rxDone) begin
            rxHold_q <= {shift_q[`SPI_WORD_BITS-2:0], serialIn};
        end
    end

    // Shift engine; slave with no new data resends old, unreported
    always_ff @(posedge clk) begin
        if (srst || doSoft) begin
            state_q      <= ST_IDLE;
            shift_q      <= `SPI_DATA_RESET;
            bitCnt_q     <= 3'h0;
            divCnt_q     <= '0;
            sck_q        <= 1'b0;
            csHeld_q     <= 1'b0;
            capBit_q     <= 1'b0;
            extraPulse_q <= 1'b0;
            prevDiv_q    <= `SPI_DIV_ONE;
        end else if (!masterMode) begin
            state_q <= ST_IDLE;
            sck_q   <= cfg.clockPolarity;
            if (fifoPop) begin
                shift_q  <= fifoData;
                csHeld_q <= 1'b1;
            end else if (slvSample) begin
                shift_q  <= {shift_q[`SPI_WORD_BITS-2:0], mosiIn};
                bitCnt_q <= bitCnt_q + 3'h1;
                csHeld_q <= !lastBit;
            end else if (ssIn_q) begin
                bitCnt_q <= 3'h0;
                csHeld_q <= 1'b0;
            end
        end else begin
            divCnt_q <= divHit || state_q == ST_IDLE ? '0
                        : divCnt_q + 1'b1;
            if (mstSample) begin
                capBit_q <= misoIn;
            end
            if (mstShift) begin
                shift_q <= {shift_q[`SPI_WORD_BITS-2:0], capBit_q};
            end
            case (state_q)
                ST_IDLE: begin
                    // Extra pulse sits inside the frame, select active
                    sck_q <= cfg.clockPolarity ^ (startMst && mismatch);
                    if (startMst) begin
                        shift_q      <= fifoData;
                        bitCnt_q     <= 3'h0;
                        state_q      <= ST_LEAD;
                        prevDiv_q    <= cfg.serialClockDivider;
                        extraPulse_q <= mismatch;
                    end
                end
                ST_LEAD: if (extraPulse_q) begin
                    sck_q        <= cfg.clockPolarity;
                    extraPulse_q <= 1'b0;
                end else if (divHit) begin
                    sck_q   <= ~sck_q;
                    state_q <= ST_TRAIL;
                end
                ST_TRAIL: if (divHit) begin
                    sck_q    <= ~sck_q;
                    bitCnt_q <= bitCnt_q + 3'h1;
                    state_q  <= lastBit ? ST_IDLE : ST_LEAD;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst || doSoft) begin
            modeFault_q <= 1'b0;
        end else begin
            modeFault_q <= masterMode && !modeFaultDetectDisable && !ssIn_q;
        end
    end

    // Select stays one cycle more so the last clock edge is framed
    always_ff @(posedge clk) begin
        if (srst || doSoft) begin
            frameTail_q <= 1'b0;
        end else begin
            frameTail_q <= masterMode && mstTrail && lastBit;
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            sckOut  <= 1'b0;
            sckOe   <= 1'b0;
            mosiOut <= 1'b0;
            mosiOe  <= 1'b0;
            misoOut <= 1'b0;
            misoOe  <= 1'b0;
            csOut_n <= '1;
            txReady <= 1'b0;
            status  <= '0;
            modeFault <= 1'b0;
        end else begin
            sckOut  <= sck_q;
            sckOe   <= masterMode && enabled_q;
            mosiOut <= shift_q[`SPI_WORD_BITS-1];
            mosiOe  <= masterMode && enabled_q;
            misoOut <= shift_q[`SPI_WORD_BITS-1];
            misoOe  <= slvSel;
            for (int i = 0; i < `SPI_NUM_CS; i++) begin
                csOut_n[i] <= !(masterMode
                               && (state_q != ST_IDLE || frameTail_q)
                               && chipSelectIndex == 2'(i));
            end
            txReady <= fifoInReady && enabled_q;
            status  <= '{receiveReadyFlag:  receive_ready_flag_q,
                         transmitEmptyFlag: txEmpty_q,
                         enabled:           enabled_q,
                         busy:              state_q != ST_IDLE || csHeld_q,
                         receiveHolding:    rxHold_q};
            modeFault <= modeFault_q;
        end
    end
endmodule

// *** logic/spi_ctrl_defs.svh ***
// Constants of the SPI controller: widths, sizes, resets, timing counts
//
// Overview of operation
// - Slave has no transmit-starved flag; unsent characters go unreported.
// - Mixed divider 1 and non-1, polarity 1, phase 0: one extra clock pulse.
// - Slave may raise receive ready spuriously at enable while the clock input is low.
// - Disable command in slave mode has no effect; controller keeps running.
// - Keep-select on select 0 with mode fault detect enabled blocks master transfers.
// - Disabled controller drops transmit writes; empty flag left unchanged.
// - Disabled during DMA feed: DMA keeps writing, words are lost.
`ifndef SPI_CTRL_DEFS_SVH
`define SPI_CTRL_DEFS_SVH
`define SPI_WORD_BITS    8
`define SPI_NUM_CS       4
`define SPI_DIV_BITS     8
`define SPI_FIFO_DEPTH   4
`define SPI_DIV_ONE      8'h01
`define SPI_DATA_RESET   8'h00
`define SPI_BIT_LAST     3'h7
`endif

// *** logic/spi_ctrl_pkg.sv ***
// Types shared by the SPI controller files
`include "spi_ctrl_defs.svh"
package spi_ctrl_pkg;
    typedef struct packed {
        logic [`SPI_DIV_BITS-1:0] serialClockDivider;
        logic                     clockPolarity;
        logic                     invertedClockPhase;
        logic                     keepSelectAfterTransfer;
    } cs_cfg_s;
    typedef struct packed {
        logic                      receiveReadyFlag;
        logic                      transmitEmptyFlag;
        logic                      enabled;
        logic                      busy;
        logic [`SPI_WORD_BITS-1:0] receiveHolding;
    } spi_status_s;
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} xfer_state_e;
endpackage

// *** sim/spi_ctrl_monitor.sv ***
// Port checker of the SPI controller
`timescale 1ns/100ps
`include "spi_ctrl_defs.svh"
module spi_ctrl_monitor
    import spi_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     srst,
    // Controls
    input wire logic                     disableCmd,
    input wire logic                     softResetBit,
    input wire logic                     masterMode,
    input wire logic                     modeFaultDetectDisable,
    input wire logic [1:0]               chipSelectIndex,
    input wire spi_ctrl_pkg::cs_cfg_s    csConfig [`SPI_NUM_CS],
    input wire logic                     txWrite,
    // Outputs
    input wire logic                     txReady,
    input wire spi_ctrl_pkg::spi_status_s status,
    input wire logic                     sckOut,
    input wire logic                     sckOe,
    input wire logic [`SPI_NUM_CS-1:0]   csOut_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire logic idlePol = csConfig[chipSelectIndex].clockPolarity;
    sequence s_off;
        !status.enabled [*3];
    endsequence
    sequence s_blocked;
        (masterMode && csConfig[0].keepSelectAfterTransfer
            && !modeFaultDetectDisable) [*4];
    endsequence
    sequence s_idle;
        (masterMode && sckOe && !status.busy && $stable(idlePol)) [*3];
    endsequence
    chk_reset_idle: assert property (
        $fell(srst) |-> csOut_n == 4'hF && !sckOe && !status.enabled)
        else $error("outputs active after reset");
    chk_slave_clock: assert property (
        !masterMode [*2] |-> !sckOe)
        else $error("slave drives the serial clock");
    chk_one_select: assert property (
        $onehot0(~csOut_n))
        else $error("more than one select asserted");
    chk_idle_level: assert property (
        s_idle |-> sckOut == idlePol)
        else $error("idle clock level differs from polarity");
    chk_slave_disable: assert property (
        !masterMode && status.enabled && disableCmd && !softResetBit
        |=> status.enabled [*3])
        else $error("disable took effect in slave mode");
    chk_held_start: assert property (
        s_blocked |-> !$rose(status.busy))
        else $error("transfer started with select held");
    chk_off_write: assert property (
        s_off ##0 (txWrite && !softResetBit)
        |=> ##1 $stable(status.transmitEmptyFlag))
        else $error("write while off changed empty flag");
    chk_ready_on: assert property (
        $rose(txReady) |-> ##[0:2] status.enabled)
        else $error("ready raised while off");
endmodule
bind spi_ctrl spi_ctrl_monitor mon (.clk, .srst, .disableCmd, .softResetBit,
    .masterMode, .modeFaultDetectDisable, .chipSelectIndex, .csConfig,
    .txWrite, .txReady, .status, .sckOut, .sckOe, .csOut_n);

// *** sim/spi_far_end.sv ***
// Behavioural far-end SPI device, slave or master
`timescale 1ns/100ps
module spi_far_end (
    // Clock and resolved lines
    input  wire logic clk,
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic selN,
    // Frame format
    input  wire logic clock_polarity,
    input  wire logic inverted_clock_phase,
    // Lines this end drives
    output logic      misoFar,
    output logic      sckFar,
    output logic      mosiFar,
    output logic      ssFar_n
);
    logic [7:0] txWord, shIn;
    logic [7:0] got[$];
    logic       sckQ, lead;
    int         cnt;
    assign sckFar = clock_polarity ^ lead;
    initial begin
        lead = 1'b0;
        mosiFar = 1'b0;
        ssFar_n = 1'b1;
        misoFar = 1'b0;
        sckQ = 1'b0;
        cnt = 0;
        txWord = 8'h00;
    end
    // Released miso toggles so a stale bit never looks valid
    always @(negedge clk) begin
        misoFar <= selN ? ~misoFar : txWord[3'(7 - cnt)];
    end
    always @(posedge clk) begin
        if (selN) begin
            cnt = 0;
        end else begin
            if (sck != sckQ && ((sck != clock_polarity) == inverted_clock_phase)) begin
                shIn = {shIn[6:0], mosi};
                cnt = cnt + 1;
                if (cnt == 8) begin
                    got.push_back(shIn);
                    cnt = 0;
                end
            end
        end
        sckQ = sck;
    end
    task automatic half();
        repeat (4) @(negedge clk);
    endtask
    // One MSB-first word as master
    task automatic send(input logic [7:0] b);
        ssFar_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (inverted_clock_phase) mosiFar = b[7-i];
            half();
            lead = 1'b1;
            if (!inverted_clock_phase) mosiFar = b[7-i];
            half();
            lead = 1'b0;
        end
        half();
        ssFar_n = 1'b1;
        mosiFar = ~mosiFar;
    endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench of the SPI controller
`timescale 1ns/100ps
`include "spi_ctrl_defs.svh"
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin \
    errCount++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
    import spi_ctrl_pkg::*;
    logic        clk, srst, enableCmd, disableCmd, softResetBit, txWrite;
    logic        masterMode, modeFaultDetectDisable, rxRead, clock_polarity, inverted_clock_phase;
    logic        txReady, modeFault, sckOut, sckOe, mosiOut, mosiOe, sckQ;
    logic        misoOut, misoOe;
    logic [1:0]  chipSelectIndex;
    logic [7:0]  txData;
    logic [3:0]  csOut_n;
    cs_cfg_s     csConfig [`SPI_NUM_CS];
    spi_status_s status;
    wire         sckW, mosiW, misoW, sckFar, mosiFar, misoFar, ssFar_n;
    int          errCount, nCompared, edges;
    logic [7:0]  expQ[$];
    assign sckW = sckOe ? sckOut : sckFar;
    assign mosiW = mosiOe ? mosiOut : mosiFar;
    assign misoW = misoOe ? misoOut : misoFar;
    spi_ctrl dut (.clk, .srst, .enableCmd, .disableCmd, .softResetBit,
        .masterMode, .modeFaultDetectDisable, .chipSelectIndex, .csConfig,
        .txWrite, .txData, .txReady, .rxRead, .status, .modeFault, .sckOut,
        .sckOe, .sckIn(sckW), .mosiOut, .mosiOe, .mosiIn(mosiW), .misoOut,
        .misoOe, .misoIn(misoW), .csOut_n, .ssIn_n(ssFar_n));
    spi_far_end far (.clk, .sck(sckW), .mosi(mosiW), .selN(&csOut_n),
        .clock_polarity, .inverted_clock_phase, .misoFar, .sckFar, .mosiFar, .ssFar_n);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (!(&csOut_n) && sckW !== sckQ) edges++;
        sckQ <= sckW;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    task automatic setCfg(input logic [7:0] dv, input logic p, input logic n);
        clock_polarity = p;
        inverted_clock_phase = n;
        foreach (csConfig[i]) csConfig[i] = '{dv, p, n, 1'b0};
    endtask
    // Push words while the buffer takes them
    task automatic fill(input int n, input bit blind = 1'b0);
        for (int i = 0; i < n; i++) begin
            txData = 8'($urandom);
            if (blind || txReady === 1'b1) txWrite = 1'b1;
            if (txReady === 1'b1) expQ.push_back(txData);
            cyc(1);
            txWrite = 1'b0;
            cyc(1);
        end
    endtask
    task automatic drain();
        int k;
        k = 0;
        cyc(4);
        while ((status.busy !== 1'b0 || status.transmitEmptyFlag !== 1'b1)
               && k < 3000) begin
            cyc(1);
            k++;
        end
        if (k >= 3000) errCount++;
        cyc(4);
    endtask
    task automatic match();
        logic [7:0] e, g;
        `CHK("count", expQ.size(), far.got.size())
        while (expQ.size() > 0 && far.got.size() > 0) begin
            e = expQ.pop_front();
            g = far.got.pop_front();
            `CHK("word", e, g)
        end
        expQ.delete();
        far.got.delete();
    endtask
    task automatic testDone();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {srst, masterMode, chipSelectIndex} = 4'hC;
        {enableCmd, disableCmd, softResetBit, txWrite, rxRead} = 5'h00;
        {modeFaultDetectDisable, txData, edges} = '0;
        setCfg(8'h02, 1'b0, 1'b1);
        void'($urandom(96181));
        cyc(6);
        srst = 1'b0;
        cyc(3);
        `CHK("txEmpty", 1'b1, status.transmitEmptyFlag)
        $display("reset test done");
        for (int m = 0; m < 4; m++) begin
            setCfg(8'h02, m[1], m[0]);
            chipSelectIndex = 2'(m);
            far.txWord = 8'($urandom);
            pulse(enableCmd);
            edges = 0;
            fill(7);
            drain();
            `CHK("edges", 16 * expQ.size(), edges)
            `CHK("rxWord", far.txWord, status.receiveHolding)
            match();
            pulse(disableCmd);
            $display("master mode %0d done", m);
        end
        fill(3, 1'b1);
        cyc(100);
        `CHK("txEmptyOff", 1'b1, status.transmitEmptyFlag)
        `CHK("lost", 0, far.got.size() + expQ.size())
        $display("disabled write test done");
        csConfig[0].keepSelectAfterTransfer = 1'b1;
        chipSelectIndex = 2'h0;
        pulse(enableCmd);
        fill(1);
        cyc(200);
        `CHK("held", 0, far.got.size())
        modeFaultDetectDisable = 1'b1;
        drain();
        match();
        pulse(disableCmd);
        $display("held select test done");
        setCfg(8'h02, 1'b1, 1'b0);
        csConfig[0].serialClockDivider = 8'h01;
        pulse(enableCmd);
        fill(1);
        drain();
        chipSelectIndex = 2'h1;
        edges = 0;
        fill(1);
        drain();
        `CHK("pulses", 18, edges)
        expQ.delete();
        far.got.delete();
        pulse(disableCmd);
        $display("divider mix test done");
        masterMode = 1'b0;
        for (int m = 0; m < 4; m++) begin
            setCfg(8'h02, m[1], m[0]);
            pulse(enableCmd);
            foreach (csConfig[i]) csConfig[i].clockPolarity = ~clock_polarity;
            cyc(2);
            foreach (csConfig[i]) csConfig[i].clockPolarity = clock_polarity;
            cyc(2);
            pulse(rxRead);
            cyc(3);
            `CHK("rxQuiet", 1'b0, status.receiveReadyFlag)
            txData = 8'($urandom);
            far.send(txData);
            cyc(4);
            `CHK("receive_ready_flag", 1'b1, status.receiveReadyFlag)
            `CHK("rxSlave", txData, status.receiveHolding)
            pulse(disableCmd);
            cyc(4);
            `CHK("stillOn", 1'b1, status.enabled)
            pulse(rxRead);
            pulse(softResetBit);
            cyc(3);
            `CHK("stopped", 1'b0, status.enabled)
            $display("slave mode %0d done", m);
        end
        testDone();
    end
    // Far beyond the fewer than two thousand cycles the tests need
    initial begin
        repeat (30000) @(posedge clk);
        errCount++;
        testDone();
    end
endmodule
